//--- design/sfsp_params.svh
`ifndef SFSP_PARAMS_SVH
`define SFSP_PARAMS_SVH

// ----------------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------------
`define SFSP_ADDR_W 17
`define SFSP_DEPTH 131072
`define SFSP_LANES 2
`define SFSP_BYTE_W 8
`define SFSP_DATA_W 16
`define SFSP_BURST_W 2

// ----------------------------------------------------------------------
// Strap and synchroniser values
// ----------------------------------------------------------------------
`define SFSP_ORDER_LINEAR 1'b0
`define SFSP_SYNC_W 3
`define SFSP_SYNC_RST 3'h5
`define SFSP_STRAP_SETTLE 2'h2

`endif

//--- design/sfsp_pkg.sv
`include "sfsp_params.svh"

package sfsp_pkg;

	// ------------------------------------------------------------------
	// Access states of the pin pipeline
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		SFSP_DESEL = 2'b00,
		SFSP_READ = 2'b01,
		SFSP_WRITE = 2'b10
	} sfsp_op_type;

	// One stored word: two lanes, eight data bits plus a parity bit each.
	typedef struct packed {
		logic [`SFSP_LANES-1:0] parity;
		logic [`SFSP_DATA_W-1:0] data;
	} sfsp_word_type;

	// Command inputs sampled together at a qualified edge.
	typedef struct packed {
		logic selected;
		logic write_n;
		logic advance;
		logic [`SFSP_LANES-1:0] lane_write_n;
	} sfsp_cmd_type;

endpackage : sfsp_pkg

//--- design/sfsp_sync.sv
`timescale 1ns/10ps
`include "sfsp_params.svh"

module sfsp_sync (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [`SFSP_SYNC_W-1:0] async_in,
	output logic [`SFSP_SYNC_W-1:0] sync_out
);
	import sfsp_pkg::*;

	logic [`SFSP_SYNC_W-1:0] meta_ff;
	logic [`SFSP_SYNC_W-1:0] sync_ff;
	logic [`SFSP_SYNC_W-1:0] nxt_meta;
	logic [`SFSP_SYNC_W-1:0] nxt_sync;

	// The first stage feeds only the second; nothing else looks at it.
	always_comb begin
		nxt_meta = async_in;
		nxt_sync = meta_ff;
	end

	// Reset value keeps the pins released and the sleep request low.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_ff <= `SFSP_SYNC_RST;
			sync_ff <= `SFSP_SYNC_RST;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign sync_out = sync_ff;

endmodule : sfsp_sync

//--- design/sfsp_top.sv
// What this block does
// (RULE_01) Select two is active high, sampled each qualified rising edge.
// (RULE_02) Select three is active low, sampled each qualified rising edge.
// (RULE_03) Selected only when select one low, two high, three low.
// (RULE_04) Output enable low lets the pins drive unless masked internally.
// (RULE_05) Output enable high keeps data and parity pins released as inputs.
// (RULE_06) Pins released during write data, first clock after deselect, deselect.
// (RULE_07) Rising edges count only while clock qualify is low.
// (RULE_08) Clock qualify high freezes all state instead of deselecting; the pin drive and sleep flops still follow output enable and sleep.
// (RULE_09) Sleep request high puts the device to sleep, memory kept.
// (RULE_10) Sleep request is low in normal use; floating reads as low.
// (RULE_11) Input data is captured into the array on the rising edge.
// (RULE_12) Reads present the word addressed at the read edge, no extra stage.
// (RULE_13) Parity pins act as data pins, written per own lane select.
// (RULE_14) Strap low gives linear burst order, high or open interleaved.
// (RULE_15) Controller drives write enable low on a qualified edge to write.
// (RULE_16) Lane write selects are active low and only act with write enable.
// (RULE_17) The word is two nine-bit lanes, each with its own select.
`timescale 1ns/10ps
`include "sfsp_params.svh"

module sfsp_top (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [`SFSP_ADDR_W-1:0] address,
	input wire logic chip_select_one_n,
	input wire logic chip_select_two,
	input wire logic chip_select_three_n,
	input wire logic clock_qualify_n,
	input wire logic write_enable_n,
	input wire logic [`SFSP_LANES-1:0] byte_lane_write_n,
	input wire logic advance_or_load,
	input wire logic output_enable_n,
	input wire logic sleep_request,
	input wire logic burst_order_strap,
	input wire sfsp_pkg::sfsp_word_type pins_in,
	output sfsp_pkg::sfsp_word_type pins_out,
	output logic data_pins_oe,
	output logic [`SFSP_LANES-1:0] parity_data_pins_oe,
	output logic sleep_active
);
	import sfsp_pkg::*;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------

	// Burst address low bits for either order.
	function automatic logic [`SFSP_BURST_W-1:0] sfsp_burst_addr(
		input logic [`SFSP_BURST_W-1:0] base,
		input logic [`SFSP_BURST_W-1:0] count,
		input logic order
	);
		if (order == `SFSP_ORDER_LINEAR) begin
			sfsp_burst_addr = base + count;
		end else begin
			sfsp_burst_addr = base ^ count;
		end
	endfunction : sfsp_burst_addr

	// ------------------------------------------------------------------
	// Asynchronous pins
	// ------------------------------------------------------------------
	logic [`SFSP_SYNC_W-1:0] sync_bus;
	logic oe_n_sync;
	logic sleep_sync;
	logic strap_sync;

	// Sleep request carries an internal pull-down in the pad, so a
	// floating pin already arrives here as low. RULE_10
	sfsp_sync u_sync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.async_in({output_enable_n, sleep_request, burst_order_strap}),
		.sync_out(sync_bus)
	);

	assign oe_n_sync = sync_bus[2];
	assign sleep_sync = sync_bus[1];
	assign strap_sync = sync_bus[0];

	// ------------------------------------------------------------------
	// Burst order strap
	// ------------------------------------------------------------------
	logic order_ff;
	logic [1:0] settle_ff;
	logic nxt_order;
	logic [1:0] nxt_settle;

	// The strap is caught once, on the third edge after reset release, when the
	// synchroniser shows the pin and no longer its own reset pattern.
	// A floating strap resolves to interleaved.
	always_comb begin
		nxt_order = order_ff;
		nxt_settle = settle_ff;
		if (settle_ff != 2'h3) begin
			nxt_settle = settle_ff + 2'h1;
		end
		if (settle_ff == `SFSP_STRAP_SETTLE) begin
			nxt_order = strap_sync; // RULE_14
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			order_ff <= 1'b1;
			settle_ff <= 2'h0;
		end else begin
			order_ff <= nxt_order;
			settle_ff <= nxt_settle;
		end
	end

	// ------------------------------------------------------------------
	// Access pipeline
	// ------------------------------------------------------------------
	sfsp_op_type op_ff;
	sfsp_op_type nxt_op;
	logic [`SFSP_ADDR_W-1:0] base_ff;
	logic [`SFSP_ADDR_W-1:0] nxt_base;
	logic [`SFSP_BURST_W-1:0] count_ff;
	logic [`SFSP_BURST_W-1:0] nxt_count;
	logic [`SFSP_LANES-1:0] lanes_n_ff;
	logic [`SFSP_LANES-1:0] nxt_lanes_n;
	logic fresh_ff;
	logic nxt_fresh;
	logic qualified;
	logic [`SFSP_ADDR_W-1:0] cur_addr;
	logic [`SFSP_ADDR_W-1:0] nxt_addr;
	sfsp_cmd_type cmd;

	assign qualified = !clock_qualify_n; // RULE_07

	// Select decode needs all three selects active at once.
	assign cmd.selected = !chip_select_one_n && chip_select_two && !chip_select_three_n; // RULE_03
	assign cmd.write_n = write_enable_n;
	assign cmd.advance = advance_or_load;
	assign cmd.lane_write_n = byte_lane_write_n;

	assign cur_addr = {base_ff[`SFSP_ADDR_W-1:`SFSP_BURST_W],
		sfsp_burst_addr(base_ff[`SFSP_BURST_W-1:0], count_ff, order_ff)};
	assign nxt_addr = {nxt_base[`SFSP_ADDR_W-1:`SFSP_BURST_W],
		sfsp_burst_addr(nxt_base[`SFSP_BURST_W-1:0], nxt_count, order_ff)};

	// Clock qualify high holds every field, stretching the previous cycle
	// rather than deselecting. Sleep acts like a deselect so no access can
	// start while the array is parked.
	always_comb begin
		nxt_op = op_ff;
		nxt_base = base_ff;
		nxt_count = count_ff;
		nxt_lanes_n = lanes_n_ff;
		nxt_fresh = fresh_ff;
		if (qualified) begin // RULE_08
			nxt_fresh = 1'b0;
			if (sleep_sync) begin
				nxt_op = SFSP_DESEL; // RULE_09
			end else if (cmd.advance) begin
				if (op_ff != SFSP_DESEL) begin
					nxt_count = count_ff + 2'h1; // RULE_14
				end
				nxt_lanes_n = cmd.lane_write_n; // RULE_16
			end else if (!cmd.selected) begin
				nxt_op = SFSP_DESEL; // RULE_01 RULE_02
			end else begin
				// Write enable low at a qualified load edge starts a write.
				nxt_op = cmd.write_n ? SFSP_READ : SFSP_WRITE; // RULE_15
				nxt_base = address;
				nxt_count = 2'h0;
				nxt_lanes_n = cmd.lane_write_n; // RULE_16
				nxt_fresh = (op_ff == SFSP_DESEL); // RULE_06
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			op_ff <= SFSP_DESEL;
			base_ff <= '0;
			count_ff <= 2'h0;
			lanes_n_ff <= 2'h3;
			fresh_ff <= 1'b0;
		end else begin
			op_ff <= nxt_op;
			base_ff <= nxt_base;
			count_ff <= nxt_count;
			lanes_n_ff <= nxt_lanes_n;
			fresh_ff <= nxt_fresh;
		end
	end

	// ------------------------------------------------------------------
	// Storage array
	// ------------------------------------------------------------------
	sfsp_word_type mem [0:`SFSP_DEPTH-1];
	sfsp_word_type rd_word;
	logic wr_cycle;

	assign wr_cycle = qualified && (op_ff == SFSP_WRITE) && !sleep_sync;
	assign rd_word = mem[nxt_addr];

	// Contents are never reset, so sleep and reset both preserve them.
	// Each lane takes its data byte and its parity bit together.
	always_ff @(posedge sys_clk) begin
		for (int k = 0; k < `SFSP_LANES; k++) begin
			if (wr_cycle && !lanes_n_ff[k]) begin // RULE_17
				mem[cur_addr].data[k*`SFSP_BYTE_W +: `SFSP_BYTE_W] <=
					pins_in.data[k*`SFSP_BYTE_W +: `SFSP_BYTE_W]; // RULE_11
				mem[cur_addr].parity[k] <= pins_in.parity[k]; // RULE_13
			end
		end
	end

	// ------------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------------
	sfsp_word_type out_ff;
	sfsp_word_type nxt_out;
	logic drive_ff;
	logic nxt_drive;
	logic sleep_ff;
	logic nxt_sleep;

	// Drive needs a read, no emergence from deselect, output enable low
	// and no sleep. Output enable passes three flops, so its effect lags
	// the pin by three clocks; that is the price of a clean crossing.
	always_comb begin
		nxt_out = out_ff;
		nxt_drive = (nxt_op == SFSP_READ) && !nxt_fresh && !oe_n_sync && !sleep_sync; // RULE_04 RULE_05 RULE_06
		nxt_sleep = sleep_sync; // RULE_09
		if (qualified && nxt_op == SFSP_READ) begin
			nxt_out = rd_word; // RULE_12
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			out_ff <= '0;
			drive_ff <= 1'b0;
			sleep_ff <= 1'b0;
		end else begin
			out_ff <= nxt_out;
			drive_ff <= nxt_drive;
			sleep_ff <= nxt_sleep;
		end
	end

	assign pins_out = out_ff;
	assign data_pins_oe = drive_ff;
	assign parity_data_pins_oe = {`SFSP_LANES{drive_ff}}; // RULE_13
	assign sleep_active = sleep_ff;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	sequence seq_load_sel;
		qualified && !advance_or_load && !sleep_sync && cmd.selected;
	endsequence

	sequence seq_write_data;
		(op_ff == SFSP_WRITE) && qualified && !sleep_sync;
	endsequence

	AST_SELECT_DECODE: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_03
		seq_load_sel |=> (op_ff != SFSP_DESEL))
		else $error("Full select did not start an access.");

	AST_SELECT_TWO_LOW: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_01
		(qualified && !advance_or_load && !chip_select_two) |=> (op_ff == SFSP_DESEL))
		else $error("Select two low did not deselect.");

	AST_SELECT_THREE_HIGH: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_02
		(qualified && !advance_or_load && chip_select_three_n) |=> (op_ff == SFSP_DESEL))
		else $error("Select three high did not deselect.");

	AST_DRIVE_ALLOWED: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_04
		(!output_enable_n [*3] ##0 seq_load_sel ##0 (write_enable_n && op_ff == SFSP_READ))
		|=> data_pins_oe)
		else $error("Pins not driven on an unmasked read.");

	AST_OE_RELEASE: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_05
		output_enable_n [*3] |=> !data_pins_oe && (parity_data_pins_oe == 2'h0))
		else $error("Pins driven while output enable high.");

	AST_MASKED_STATES: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_06
		(op_ff != SFSP_READ || fresh_ff) |-> !data_pins_oe)
		else $error("Pins driven in write, deselect or first clock after deselect.");

	AST_WRITE_RELEASE: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_06
		(seq_load_sel ##0 !write_enable_n) |=> !data_pins_oe && (parity_data_pins_oe == 2'h0))
		else $error("Pins driven during the data cycle of a write.");

	AST_STRETCH: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_08
		clock_qualify_n |=> $stable(op_ff) && $stable(base_ff) && $stable(count_ff))
		else $error("State moved while clock qualify high.");

	AST_SLEEP: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_09
		sleep_request [*3] |=> sleep_active && !data_pins_oe)
		else $error("Sleep request did not park the pins.");

	AST_WRITE_LANE: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_11
		(seq_write_data ##0 !lanes_n_ff[0]) |=>
		(mem[$past(cur_addr)].data[7:0] == $past(pins_in.data[7:0])) &&
		(mem[$past(cur_addr)].parity[0] == $past(pins_in.parity[0])))
		else $error("Lane zero write data not stored.");

	AST_READ_DATA: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_12
		(qualified && nxt_op == SFSP_READ && op_ff != SFSP_WRITE) |=>
		(pins_out == mem[cur_addr]))
		else $error("Read data does not match addressed word.");

	AST_BURST_STEP: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_14
		(qualified && advance_or_load && !sleep_sync && op_ff != SFSP_DESEL) |=>
		(count_ff == $past(count_ff) + 2'h1))
		else $error("Burst count did not advance.");

endmodule : sfsp_top

//--- dv/sfsp_ctrl_model.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Controller side of the shared data and parity wires
// ----------------------------------------------------------------------
module sfsp_ctrl_model (
	input wire logic sys_clk,
	input wire logic drive_en,
	input wire sfsp_pkg::sfsp_word_type wdata,
	input wire sfsp_pkg::sfsp_word_type pins_out,
	input wire logic data_pins_oe,
	output sfsp_pkg::sfsp_word_type pins_in
);
	import sfsp_pkg::*;

	sfsp_word_type last_ff = '0;

	// The wire has no keeper, so a released bus shows a changing pattern, not stale data.
	always_ff @(posedge sys_clk) begin
		last_ff <= pins_in;
	end

	// The device wins the wire while it drives; the controller only drives write data.
	assign pins_in = data_pins_oe ? pins_out : (drive_en ? wdata : ~last_ff);
endmodule : sfsp_ctrl_model

//--- dv/sync_flowthrough_sram_pins_test.sv
`timescale 1ns/10ps
`include "sfsp_params.svh"

module sync_flowthrough_sram_pins_test;
	import sfsp_pkg::*;

	// ------------------------------------------------------------------
	// Stimulus, reference state and counters
	// ------------------------------------------------------------------
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [`SFSP_ADDR_W-1:0] address = '0;
	logic chip_select_one_n = 1'b1, chip_select_two = 1'b0, chip_select_three_n = 1'b1;
	logic clock_qualify_n = 1'b0, write_enable_n = 1'b1, advance_or_load = 1'b0;
	logic [1:0] byte_lane_write_n = 2'h3;
	logic output_enable_n = 1'b0, sleep_request = 1'b0, burst_order_strap = 1'b1;
	logic drive_en = 1'b0, data_pins_oe, sleep_active;
	logic [1:0] parity_data_pins_oe;
	logic [2:0] oe_pipe;
	sfsp_word_type pins_in, pins_out, wdata = '0;
	logic [17:0] mem [int];
	int error_cnt = 0, n_tests = 0, op = 0, order = 1, base = 0, cnt = 0;
	bit fresh = 1'b0;

	// Free-running 40 MHz clock.
	always #12.5 sys_clk = ~sys_clk;

	// Output enable reaches the pins three edges late, so the reference follows it the same way.
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			oe_pipe <= 3'h7;
		end else begin
			oe_pipe <= {oe_pipe[1:0], output_enable_n};
		end
	end

	sfsp_top i_sfsp_top (.sys_clk, .reset_n, .address, .chip_select_one_n, .chip_select_two,
		.chip_select_three_n, .clock_qualify_n, .write_enable_n, .byte_lane_write_n,
		.advance_or_load, .output_enable_n, .sleep_request, .burst_order_strap, .pins_in,
		.pins_out, .data_pins_oe, .parity_data_pins_oe, .sleep_active);

	sfsp_ctrl_model i_sfsp_ctrl_model (.sys_clk, .drive_en, .wdata, .pins_out, .data_pins_oe,
		.pins_in);

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish

	task automatic step();
		@(posedge sys_clk);
		#2;
	endtask : step

	// Word address reached by the burst counter.
	function automatic int ba();
		int lo;
		lo = order ? (base[1:0] ^ cnt[1:0]) : (base[1:0] + cnt[1:0]);
		return {base[31:2], lo[1:0]};
	endfunction : ba

	// One qualified edge, then the reference steps and the pins are compared.
	task automatic cmd(input logic [2:0] cs, input logic we, input logic adv, input int a,
		input logic [1:0] l);
		logic sel;
		{chip_select_one_n, chip_select_two, chip_select_three_n} = cs;
		write_enable_n = we;
		advance_or_load = adv;
		address = a[16:0];
		byte_lane_write_n = l;
		step();
		sel = (cs == 3'b010) && !sleep_request;
		if (!adv) begin
			fresh = (op == 0);
			op = sel ? (we ? 1 : 2) : 0;
			base = a;
			cnt = 0;
		end else if (op != 0) begin
			fresh = 1'b0;
			cnt++;
		end
		// The controller drives write data for the cycle after each write edge.
		drive_en = (op == 2);
		chk(18'(parity_data_pins_oe), 18'({2{data_pins_oe}}));
		chk(data_pins_oe, op == 1 && !fresh && !oe_pipe[2]);
		if (op == 1 && !fresh) chk(pins_out, mem[ba()]);
	endtask : cmd

	// Write command; its data is handed over for capture at the following qualified edge.
	task automatic wr(input int a, input logic [1:0] l);
		logic [17:0] d, m;
		cmd(3'b010, 1'b0, 1'b0, a, l);
		d = 18'($urandom());
		wdata = d;
		m = mem.exists(a) ? mem[a] : 18'hx;
		for (int k = 0; k < 2; k++) begin
			if (!l[k]) begin
				m[8*k +: 8] = d[8*k +: 8];
				m[16+k] = d[16+k];
			end
		end
		mem[a] = m;
	endtask : wr

	task automatic do_reset(input logic s);
		{chip_select_one_n, chip_select_two, chip_select_three_n} = 3'b111;
		burst_order_strap = s;
		reset_n = 1'b0;
		repeat (12) step();
		reset_n = 1'b1;
		order = s;
		op = 0;
		repeat (4) cmd(3'b111, 1'b1, 1'b0, 0, 2'h3);
	endtask : do_reset

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	initial begin
		void'($urandom(32'h5416b2e8));
		for (int s = 0; s < 2; s++) begin
			do_reset(s[0]);
			for (int i = 0; i < 4; i++) wr(32'h100 + i, 2'h0);
			cmd(3'b010, 1'b1, 1'b0, 32'h101, 2'h3);
			repeat (3) cmd(3'b000, 1'b1, 1'b1, 0, 2'h3);
		end
		for (int k = 0; k < 8; k++) wr(k, 2'h0);
		for (int k = 0; k < 8; k++) wr(k, k[1:0]);
		for (int k = 0; k < 8; k++) begin
			cmd(3'b010, 1'b1, 1'b0, k, 2'h3);
			cmd(k[2:0], 1'b1, 1'b0, 7 - k, 2'h3);
		end
		cmd(3'b010, 1'b1, 1'b0, 4, 2'h3);
		cmd(3'b010, 1'b1, 1'b0, 5, 2'h3);
		// Stalled edges carry junk commands that must leave everything as it was.
		clock_qualify_n = 1'b1;
		repeat (3) begin
			{chip_select_one_n, chip_select_two, chip_select_three_n, address} = 20'($urandom());
			write_enable_n = 1'b0;
			step();
			chk(pins_out, mem[5]);
			chk(data_pins_oe, 1'b1);
		end
		clock_qualify_n = 1'b0;
		cmd(3'b000, 1'b1, 1'b1, 0, 2'h3);
		wr(6, 2'h1);
		clock_qualify_n = 1'b1;
		repeat (2) step();
		clock_qualify_n = 1'b0;
		cmd(3'b010, 1'b1, 1'b0, 7, 2'h3);
		cmd(3'b010, 1'b1, 1'b0, 6, 2'h3);
		output_enable_n = 1'b1;
		repeat (5) cmd(3'b010, 1'b1, 1'b0, 1, 2'h3);
		output_enable_n = 1'b0;
		repeat (4) cmd(3'b010, 1'b1, 1'b0, 2, 2'h3);
		sleep_request = 1'b1;
		repeat (4) cmd(3'b111, 1'b1, 1'b0, 0, 2'h3);
		chk(sleep_active, 1'b1);
		cmd(3'b010, 1'b1, 1'b0, 2, 2'h3);
		sleep_request = 1'b0;
		repeat (4) cmd(3'b111, 1'b1, 1'b0, 0, 2'h3);
		chk(sleep_active, 1'b0);
		cmd(3'b010, 1'b1, 1'b0, 2, 2'h3);
		cmd(3'b010, 1'b1, 1'b0, 3, 2'h3);
		tally_and_finish();
	end

	// A hang is cut short well beyond the hundred or so cycles the scenarios need.
	initial begin
		#100000;
		error_cnt++;
		tally_and_finish();
	end
endmodule : sync_flowthrough_sram_pins_test
